// file: flash_regs.svh
// Constants for the parallel NOR flash host controller.
// Assumes a 100 MHz clk_sys; times are in ns and rounded up to cycles.
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// ==========================================================
// Bus widths and field positions
`define FL_AW           21
`define FL_DW           16
`define POLL_BIT        7
`define TIMEOUT_BIT     5
`define ABORT_BIT       1
`define SECT_LSB        12
`define BUF_IDX_W       4

// ==========================================================
// Unlock cycles and command codes (plain defaults)
`define UNLOCK1_ADDR    21'h000555
`define UNLOCK1_DATA    8'haa
`define UNLOCK2_ADDR    21'h0002aa
`define UNLOCK2_DATA    8'h55
`define CMD_RESET       8'hf0
`define CMD_AUTOSEL     8'h90
`define CMD_PROG        8'ha0
`define CMD_SUSPEND     8'hb0
`define CMD_RESUME      8'h30
`define CMD_BUF_LOAD    8'h25
`define CMD_BUF_CONFIRM 8'h29
`define CMD_BUF_ABORT   8'hf0

// ==========================================================
// Timing in ns and derived cycle counts
`define CLK_NS          10
`define CYC_MIN(ns)     (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_SETUP_NS      20
`define T_WP_NS         40
`define T_HOLD_NS       30
`define T_ACC_NS        100
`define T_SPD_NS        1000
`define T_RSM_NS        4000
`define SETUP_CYC       `CYC_MIN(`T_SETUP_NS)
`define WP_CYC          `CYC_MIN(`T_WP_NS)
`define HOLD_CYC        `CYC_MIN(`T_HOLD_NS)
`define ACC_CYC         `CYC_MIN(`T_ACC_NS)
`define SPD_CYC         `CYC_MIN(`T_SPD_NS)
`define RSM_CYC         `CYC_MIN(`T_RSM_NS)

`endif

// file: flash_pkg.sv
// Types shared by the flash host controller and its bus cycle engine.
// Assumes flash_regs.svh is on the include path.
`include "flash_regs.svh"

package flash_pkg;
  typedef logic [`FL_AW-1:0] faddr_t;
  typedef logic [`FL_DW-1:0] fdata_t;

  // User operations
  typedef enum logic [3:0] {
    OP_READ      = 4'h0,
    OP_RESET     = 4'h1,
    OP_ID_ENTER  = 4'h2,
    OP_PROG      = 4'h3,
    OP_BUF_LOAD  = 4'h4,
    OP_BUF_PROG  = 4'h5,
    OP_POLL      = 4'h6,
    OP_SUSPEND   = 4'h7,
    OP_RESUME    = 4'h8,
    OP_ABORT_RST = 4'h9
  } op_e;

  // Answer status
  typedef enum logic [1:0] {
    ST_OK    = 2'h0,
    ST_FAIL  = 2'h1,
    ST_ABORT = 2'h2
  } status_e;
endpackage : flash_pkg

// file: flash_cycle_if.sv
// Carries one flash bus cycle request between sequencer and engine.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
`default_nettype none

interface flash_cycle_if;
  import flash_pkg::*;
  logic   req;
  logic   wr;
  faddr_t addr;
  fdata_t wdata;
  logic   done;
  fdata_t rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave  (input req, wr, addr, wdata, output done, rdata);
endinterface : flash_cycle_if

`default_nettype wire

// file: flash_bus_cycle.sv
// Bus cycle engine: one strobed write or read on the flash pins.
// Assumes dq_in is synchronous to clk_sys and settles within the access time.
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs.svh"

module flash_bus_cycle
  import flash_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Cycle requests
  flash_cycle_if.slave cyc,
  // Flash pins
  output logic      ce_n,
  output logic      we_n,
  output logic      oe_n,
  output faddr_t    fl_addr,
  output fdata_t    dq_out,
  output logic      dq_oe,
  input  wire fdata_t dq_in
);
  typedef enum logic [1:0] {
    B_IDLE = 2'h0, B_SETUP = 2'h1, B_STROBE = 2'h2, B_HOLD = 2'h3
  } bstate_e;

  bstate_e    state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       wr_reg, wr_next;
  logic       ce_n_next, we_n_next, oe_n_next, dq_oe_next;
  faddr_t     addr_next;
  fdata_t     dq_out_next, rdata_reg, rdata_next;

  // ==========================================================
  // Strobe sequencing
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    ce_n_next   = ce_n;
    we_n_next   = we_n;
    oe_n_next   = oe_n;
    dq_oe_next  = dq_oe;
    addr_next   = fl_addr;
    dq_out_next = dq_out;
    rdata_next  = rdata_reg;
    cyc.done    = 1'b0;
    case (state_reg)
      B_IDLE:
        if (cyc.req)
        begin
          addr_next   = cyc.addr;
          dq_out_next = cyc.wdata;
          wr_next     = cyc.wr;
          ce_n_next   = 1'b0;
          cnt_next    = 4'(`SETUP_CYC - 1);
          state_next  = B_SETUP;
        end
      B_SETUP:
        if (cnt_reg == 4'h0)
        begin
          // Write keeps oe_n high while we_n falls
          we_n_next  = !wr_reg;
          oe_n_next  = wr_reg;
          dq_oe_next = wr_reg;
          cnt_next   = wr_reg ? 4'(`WP_CYC - 1) : 4'(`ACC_CYC - 1);
          state_next = B_STROBE;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      B_STROBE:
        if (cnt_reg == 4'h0)
        begin
          if (!wr_reg)
            rdata_next = dq_in;
          we_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          ce_n_next  = 1'b1;
          cnt_next   = 4'(`HOLD_CYC - 1);
          state_next = B_HOLD;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      default:
        if (cnt_reg == 4'h0)
        begin
          cyc.done   = 1'b1;
          dq_oe_next = 1'b0;
          state_next = B_IDLE;
        end
        else
          cnt_next = cnt_reg - 4'h1;
    endcase
  end

  // Pin and state registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= B_IDLE;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
      ce_n      <= 1'b1;
      we_n      <= 1'b1;
      oe_n      <= 1'b1;
      dq_oe     <= 1'b0;
      fl_addr   <= '0;
      dq_out    <= '0;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      ce_n      <= ce_n_next;
      we_n      <= we_n_next;
      oe_n      <= oe_n_next;
      dq_oe     <= dq_oe_next;
      fl_addr   <= addr_next;
      dq_out    <= dq_out_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cyc.rdata = rdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_write_strobe_qual: assert property (!we_n |-> !ce_n && oe_n)
    else $error("write strobe without chip enable or with output enable");
  a_we_pulse_width: assert property ($fell(we_n) |-> (!we_n)[*4] ##1 we_n)
    else $error("write strobe width wrong");
  a_wdata_stable: assert property (!we_n |-> dq_oe && $stable(dq_out) && $stable(fl_addr))
    else $error("data or address moved during write strobe");
  a_cycle_bounded: assert property ((state_reg == B_IDLE && cyc.req) |-> ##[8:16] cyc.done)
    else $error("bus cycle did not finish in time");
endmodule : flash_bus_cycle

`default_nettype wire

// file: flash_host_ctrl.sv
// Host controller for a parallel NOR flash: command sequences and polling.
// Assumes user commands are synchronous to clk_sys and ready_busy_in is
// synchronised outside; the flash data bus is joined from dq_out/dq_oe.
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs.svh"

module flash_host_ctrl
  import flash_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_sys,
  input  wire logic    rst_n,
  // User command port
  input  wire logic    cmd_valid,
  output logic         cmd_ready,
  input  wire op_e     cmd_op,
  input  wire faddr_t  cmd_addr,
  input  wire fdata_t  cmd_data,
  // User answer port
  output logic         rsp_valid,
  output fdata_t       rsp_data,
  output status_e      rsp_status,
  output logic         suspended,
  output logic         id_mode,
  // Flash pins
  output logic         ce_n,
  output logic         we_n,
  output logic         oe_n,
  output faddr_t       fl_addr,
  output fdata_t       dq_out,
  output logic         dq_oe,
  input  wire fdata_t  dq_in,
  input  wire logic    ready_busy_in
);
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_STEP = 3'h1, M_READ = 3'h2, M_POLL = 3'h3,
    M_WAIT = 3'h4, M_RESP = 3'h5
  } mstate_e;

  flash_cycle_if cyc ();

  mstate_e    state_reg, state_next;
  op_e        op_reg, op_next;
  faddr_t     addr_reg, addr_next, paddr_reg, paddr_next, st_addr, base;
  fdata_t     data_reg, data_next, pdata_reg, pdata_next, st_data;
  fdata_t     rdata_next, buf_mem [16];
  status_e    stat_next;
  logic [4:0] idx_reg, idx_next, woff;
  logic [3:0] bcnt_reg, bcnt_next;
  logic [11:0] timer_reg, timer_next, age_reg, age_next;
  logic       st_last, poll2_reg, poll2_next, early_reg, early_next;
  logic       active_reg, active_next, isbuf_reg, isbuf_next;
  logic       susp_next, id_next, buf_we;

  // ==========================================================
  // Cycle engine
  flash_bus_cycle u_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cyc     (cyc.slave),
    .ce_n    (ce_n),
    .we_n    (we_n),
    .oe_n    (oe_n),
    .fl_addr (fl_addr),
    .dq_out  (dq_out),
    .dq_oe   (dq_oe),
    .dq_in   (dq_in)
  );

  // ==========================================================
  // Step table: address and data of each bus write of a sequence
  assign base = {addr_reg[`FL_AW-1:4], 4'h0};
  assign woff = idx_reg - 5'd4;

  always_comb
  begin
    st_addr = `UNLOCK1_ADDR;
    st_data = {8'h00, `UNLOCK1_DATA};
    st_last = 1'b0;
    case (op_reg)
      OP_RESET, OP_SUSPEND, OP_RESUME:
      begin
        st_addr = addr_reg;
        st_last = 1'b1;
        st_data = (op_reg == OP_RESET)   ? {8'h00, `CMD_RESET} :
                  (op_reg == OP_SUSPEND) ? {8'h00, `CMD_SUSPEND} : {8'h00, `CMD_RESUME};
      end
      OP_ID_ENTER:
        if (idx_reg == 5'd0)
          st_data = {8'h00, `CMD_RESET};
        else if (idx_reg == 5'd2)
        begin
          st_addr = `UNLOCK2_ADDR;
          st_data = {8'h00, `UNLOCK2_DATA};
        end
        else if (idx_reg == 5'd3)
        begin
          st_data = {8'h00, `CMD_AUTOSEL};
          st_last = 1'b1;
        end
      default:
        if (idx_reg == 5'd1)
        begin
          st_addr = `UNLOCK2_ADDR;
          st_data = {8'h00, `UNLOCK2_DATA};
        end
        else if (idx_reg != 5'd0)
        begin
          if (op_reg == OP_PROG)
          begin
            st_data = (idx_reg == 5'd2) ? {8'h00, `CMD_PROG} : data_reg;
            st_addr = (idx_reg == 5'd2) ? `UNLOCK1_ADDR : addr_reg;
            st_last = (idx_reg == 5'd3);
          end
          else if (op_reg == OP_BUF_PROG)
          begin
            st_addr = base;
            if (idx_reg == 5'd2)
              st_data = {8'h00, `CMD_BUF_LOAD};
            else if (idx_reg == 5'd3)
              st_data = {12'h000, bcnt_reg};
            else if (woff <= {1'b0, bcnt_reg})
            begin
              st_addr = base + faddr_t'(woff[3:0]);
              st_data = buf_mem[woff[3:0]];
            end
            else
            begin
              st_data = {8'h00, `CMD_BUF_CONFIRM};
              st_last = 1'b1;
            end
          end
          else
          begin
            st_data = {8'h00, `CMD_BUF_ABORT};
            st_last = 1'b1;
          end
        end
    endcase
  end

  // ==========================================================
  // Sequencer next state
  assign cyc.req   = (state_reg == M_STEP) || (state_reg == M_READ) || (state_reg == M_POLL);
  assign cyc.wr    = (state_reg == M_STEP);
  assign cyc.addr  = (state_reg == M_POLL) ? paddr_reg : (state_reg == M_READ) ? addr_reg : st_addr;
  assign cyc.wdata = st_data;
  assign cmd_ready = (state_reg == M_IDLE);
  assign rsp_valid = (state_reg == M_RESP);

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    paddr_next = paddr_reg;
    pdata_next = pdata_reg;
    idx_next = idx_reg;
    bcnt_next = bcnt_reg;
    timer_next = timer_reg;
    poll2_next = poll2_reg;
    early_next = early_reg;
    active_next = active_reg;
    isbuf_next = isbuf_reg;
    susp_next = suspended;
    id_next = id_mode;
    rdata_next = rsp_data;
    stat_next = rsp_status;
    buf_we = 1'b0;
    // Program age saturates at the resume hold-off count
    age_next = (active_reg && !suspended && age_reg < 12'(`RSM_CYC)) ? age_reg + 12'h1 : age_reg;
    case (state_reg)
      M_IDLE:
        if (cmd_valid)
        begin
          op_next = cmd_op;
          addr_next = cmd_addr;
          data_next = cmd_data;
          stat_next = ST_OK;
          rdata_next = '0;
          poll2_next = 1'b0;
          idx_next = (cmd_op == OP_ID_ENTER && suspended) ? 5'd1 : 5'd0;
          if (cmd_op == OP_BUF_PROG)
            bcnt_next = cmd_data[3:0];
          case (cmd_op)
            OP_READ:     state_next = M_READ;
            OP_POLL:     state_next = active_reg ? M_POLL : M_RESP;
            OP_BUF_LOAD:
            begin
              buf_we = 1'b1;
              state_next = M_RESP;
            end
            OP_SUSPEND:  state_next = (active_reg && !suspended) ? M_STEP : M_RESP;
            OP_RESUME:   state_next = suspended ? M_STEP : M_RESP;
            default:     state_next = M_STEP;
          endcase
        end
      M_STEP:
        if (cyc.done)
        begin
          idx_next = idx_reg + 5'd1;
          state_next = M_RESP;
          if (!st_last)
            state_next = M_STEP;
          else if (op_reg == OP_PROG || op_reg == OP_BUF_PROG)
          begin
            // Remember the word to poll: last loaded one for buffers
            paddr_next = (op_reg == OP_PROG) ? addr_reg : base + faddr_t'(bcnt_reg);
            pdata_next = (op_reg == OP_PROG) ? data_reg : buf_mem[bcnt_reg];
            active_next = 1'b1;
            isbuf_next = (op_reg == OP_BUF_PROG);
            age_next = 12'h0;
          end
          else if (op_reg == OP_SUSPEND)
          begin
            susp_next = 1'b1;
            early_next = (age_reg < 12'(`RSM_CYC));
            timer_next = 12'(`SPD_CYC);
            state_next = M_WAIT;
          end
          else if (op_reg == OP_RESUME)
          begin
            susp_next = 1'b0;
            timer_next = 12'(`RSM_CYC);
            state_next = early_reg ? M_WAIT : M_RESP;
          end
          else if (op_reg == OP_ID_ENTER)
            id_next = 1'b1;
          else if (op_reg == OP_RESET)
            id_next = 1'b0;
        end
      M_READ:
        if (cyc.done)
        begin
          rdata_next = cyc.rdata;
          state_next = M_RESP;
        end
      M_POLL:
        if (cyc.done)
        begin
          rdata_next = cyc.rdata;
          if (cyc.rdata[`POLL_BIT] == pdata_reg[`POLL_BIT])
          begin
            active_next = 1'b0;
            state_next = M_RESP;
          end
          else if (poll2_reg)
          begin
            stat_next = ST_FAIL;
            state_next = M_RESP;
          end
          // Ready may rise after the status word was sampled: read once more
          else if (cyc.rdata[`TIMEOUT_BIT] || (ready_busy_in && !suspended))
            poll2_next = 1'b1;
          else if (cyc.rdata[`ABORT_BIT] && isbuf_reg)
          begin
            active_next = 1'b0;
            stat_next = ST_ABORT;
            state_next = M_RESP;
          end
        end
      M_WAIT:
        if (timer_reg <= 12'h1)
          state_next = M_RESP;
        else
          timer_next = timer_reg - 12'h1;
      default:
        state_next = M_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= M_IDLE;
      op_reg <= OP_READ;
      addr_reg <= '0;
      data_reg <= '0;
      paddr_reg <= '0;
      pdata_reg <= '0;
      idx_reg <= 5'h00;
      bcnt_reg <= 4'h0;
      timer_reg <= 12'h000;
      age_reg <= 12'h000;
      poll2_reg <= 1'b0;
      early_reg <= 1'b0;
      active_reg <= 1'b0;
      isbuf_reg <= 1'b0;
      suspended <= 1'b0;
      id_mode <= 1'b0;
      rsp_data <= '0;
      rsp_status <= ST_OK;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      paddr_reg <= paddr_next;
      pdata_reg <= pdata_next;
      idx_reg <= idx_next;
      bcnt_reg <= bcnt_next;
      timer_reg <= timer_next;
      age_reg <= age_next;
      poll2_reg <= poll2_next;
      early_reg <= early_next;
      active_reg <= active_next;
      isbuf_reg <= isbuf_next;
      suspended <= susp_next;
      id_mode <= id_next;
      rsp_data <= rdata_next;
      rsp_status <= stat_next;
    end
  end

  // Write buffer, indexed by the low address bits
  always_ff @(posedge clk_sys)
  begin
    if (buf_we)
      buf_mem[cmd_addr[3:0]] <= cmd_data;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_resume_done;
    state_reg == M_STEP && cyc.done && op_reg == OP_RESUME && early_reg;
  endsequence
  sequence s_hold_off;
    (state_reg == M_WAIT)[*8];
  endsequence

  a_prog_unlock_first: assert property (cyc.req && cyc.wr && op_reg == OP_PROG && idx_reg == 5'd0
      |-> cyc.addr == `UNLOCK1_ADDR && cyc.wdata[7:0] == `UNLOCK1_DATA)
    else $error("program does not open with first unlock");
  a_id_reset_first: assert property (cyc.req && op_reg == OP_ID_ENTER && idx_reg == 5'd0
      |-> cyc.wdata == {8'h00, `CMD_RESET})
    else $error("identification entry not preceded by reset");
  a_poll_same_addr: assert property (state_reg == M_POLL && !oe_n |-> fl_addr == paddr_reg)
    else $error("poll read away from programmed address");
  a_buf_start_align: assert property (cyc.req && op_reg == OP_BUF_PROG && idx_reg == 5'd4
      |-> cyc.addr[3:0] == 4'h0)
    else $error("buffer load not aligned");
  a_buf_count_cycle: assert property (cyc.req && op_reg == OP_BUF_PROG && idx_reg == 5'd3
      |-> cyc.addr[`FL_AW-1:`SECT_LSB] == addr_reg[`FL_AW-1:`SECT_LSB])
    else $error("count cycle outside sector");
  a_resume_hold_off: assert property (s_resume_done |=> s_hold_off)
    else $error("status read too soon after resume");
  a_suspend_wait: assert property (state_reg == M_STEP && cyc.done && op_reg == OP_SUSPEND
      |=> !cmd_ready [*8])
    else $error("suspend wait skipped");
  a_cmd_upper_zero: assert property (cyc.req && cyc.wr && op_reg inside {OP_RESET, OP_SUSPEND,
      OP_RESUME, OP_ID_ENTER} |-> cyc.wdata[15:8] == 8'h00)
    else $error("command upper byte not zero");
endmodule : flash_host_ctrl

`default_nettype wire

// file: flash_dev_model.sv
// Behavioural flash device on the controller's flash pins.
// Assumes strobes change on rising clk_sys edges; the model acts on falling ones.
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs.svh"
// ====================
// Device model
module flash_dev_model
  import flash_pkg::*;
#(
  parameter fdata_t MAKER = 16'h00c3, // Arbitrary
  parameter fdata_t DEVC  = 16'h1234  // Arbitrary
)
(
  // Pins
  input  wire logic   clk_sys,
  input  wire logic   ce_n,
  input  wire logic   we_n,
  input  wire logic   oe_n,
  input  wire faddr_t fl_addr,
  input  wire fdata_t dq_out,
  // Ordered fault: reject the confirm
  input  wire logic   bad_cfm,
  // Answers
  output fdata_t      dq_in,
  output logic        ready_busy_in
);
  fdata_t mem [faddr_t];
  fdata_t bb [16];
  faddr_t la, pa;
  fdata_t pd;
  logic wp = 1, id = 0, su = 0, ab = 0, fl = 0, bm = 0;
  int st = 0, bs = 0, n = 0, tmr = 0, nz = 0;
  logic [7:0] c;

  // Erased cells read all ones
  function automatic fdata_t rd(faddr_t a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : rd

  // Command decode on rising write strobe, program timer
  // Runs mid-cycle so answers never move on the controller's sampling edge
  always @(negedge clk_sys)
  begin
    nz = nz + 1;
    if (wp && !we_n)
      la = fl_addr;
    if (!wp && we_n)
    begin
      c = dq_out[7:0];
      if (bs == 1)
      begin
        n = c[3:0];
        bs = 2;
      end
      else if (bs == 2)
      begin
        bb[la[3:0]] = dq_out;
        bs = (la[3:0] == n[3:0]) ? 3 : 2;
      end
      else if (bs == 3)
      begin
        bs = 0;
        ab = !(c == `CMD_BUF_CONFIRM && la[20:12] == pa[20:12] && !bad_cfm);
        pa[3:0] = n[3:0];
        pd = bb[n];
        bm = 1;
        tmr = ab ? 0 : 300;
      end
      else if (st == 3)
      begin
        pa = la;
        pd = dq_out;
        bm = 0;
        tmr = 300;
        st = 0;
      end
      else if (c == `CMD_SUSPEND)
        su = tmr > 0;
      else if (c == `CMD_RESUME)
        su = 0;
      else if (c == `CMD_RESET)
      begin
        id = 0;
        fl = 0;
        ab = 0;
        st = 0;
      end
      else if (st == 2)
      begin
        id = id | (c == `CMD_AUTOSEL);
        bs = (c == `CMD_BUF_LOAD) ? 1 : 0;
        pa = bs ? la : pa;
        st = (c == `CMD_PROG) ? 3 : 0;
      end
      else
        st = (st == 0 && c == `UNLOCK1_DATA && la == `UNLOCK1_ADDR) ? 1 :
             (st == 1 && c == `UNLOCK2_DATA) ? 2 : 0;
    end
    wp = we_n;
    if (tmr > 0 && !su)
    begin
      tmr = tmr - 1;
      if (tmr == 0 && bm)
        for (int k = 0; k <= n; k++)
          mem[{pa[20:4], 4'(k)}] = rd({pa[20:4], 4'(k)}) & bb[k];
      else if (tmr == 0)
      begin
        fl = (rd(pa) & pd) != pd;
        mem[pa] = rd(pa) & pd;
      end
    end
  end

  // Read data; a released bus shows a changing pattern
  always_comb
  begin
    dq_in = fdata_t'(nz * 40503);
    if (!ce_n && !oe_n)
      dq_in = id ? (fl_addr[3:0] == 0 ? MAKER : fl_addr[3:0] == 1 ? DEVC : 16'h0)
            : ((tmr > 0 && !su) || ab) ? {8'h0, ~pd[7], nz[2], 4'h0, ab, 1'b0}
            : rd(fl_addr) | {10'h0, fl, 5'h0};
  end
  assign ready_busy_in = !((tmr > 0 && !su) || ab);
endmodule : flash_dev_model
`default_nettype wire

// file: nor_flash_command_sequencer_tb_top.sv
// Self-checking bench for the flash host controller.
// Assumes flash_dev_model stands on the flash pins.
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench
module nor_flash_command_sequencer_tb_top;
  import flash_pkg::*;
  logic clk_sys = 0, rst_n = 0, cmd_valid = 0, bad_cfm = 0;
  op_e cmd_op = OP_READ;
  faddr_t cmd_addr = '0, fl_addr;
  fdata_t cmd_data = '0, rsp_data, dq_out, dq_in;
  status_e rsp_status;
  logic cmd_ready, rsp_valid, suspended, id_mode, ce_n, we_n, oe_n, dq_oe, ready_busy_in;
  int num_errors = 0, checks = 0, cyc = 0;

  flash_host_ctrl dut_u (.clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
    .cmd_data, .rsp_valid, .rsp_data, .rsp_status, .suspended, .id_mode, .ce_n, .we_n,
    .oe_n, .fl_addr, .dq_out, .dq_oe, .dq_in, .ready_busy_in);
  flash_dev_model dev_u (.clk_sys, .ce_n, .we_n, .oe_n, .fl_addr, .dq_out, .bad_cfm,
    .dq_in, .ready_busy_in);

  // Clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // Compare one value
  task automatic chk(string nm, fdata_t e, fdata_t s);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  // Offer one command, wait for its answer, compare it
  task automatic run(op_e op, faddr_t a, fdata_t d, status_e es, fdata_t ed, bit cd = 1);
    @(negedge clk_sys);
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1)
      @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 0;
    while (rsp_valid !== 1'b1)
      @(negedge clk_sys);
    chk("status", fdata_t'(es), fdata_t'(rsp_status));
    if (cd)
      chk("data", ed, rsp_data);
  endtask : run

  task automatic endt(string nm);
    $display("test %s done", nm);
  endtask : endt

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Test sequence
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    run(OP_READ, 21'h100, 0, ST_OK, 16'hffff);
    run(OP_ID_ENTER, 21'h0, 0, ST_OK, 0);
    chk("id_mode", 1, id_mode);
    run(OP_READ, 21'h0, 0, ST_OK, dev_u.MAKER);
    run(OP_READ, 21'h1, 0, ST_OK, dev_u.DEVC);
    run(OP_RESET, 21'h0, 0, ST_OK, 0);
    run(OP_READ, 21'h0, 0, ST_OK, 16'hffff);
    endt("identification");
    run(OP_PROG, 21'h100, 16'h1234, ST_OK, 0);
    run(OP_POLL, 21'h100, 0, ST_OK, 16'h1234);
    run(OP_PROG, 21'h100, 16'h12b4, ST_OK, 0);
    run(OP_POLL, 21'h100, 0, ST_FAIL, 0, 0);
    run(OP_RESET, 21'h0, 0, ST_OK, 0);
    run(OP_READ, 21'h100, 0, ST_OK, 16'h1234);
    endt("program");
    run(OP_PROG, 21'h200, 16'h5678, ST_OK, 0);
    run(OP_SUSPEND, 21'h200, 0, ST_OK, 0);
    chk("suspended", 1, suspended);
    run(OP_READ, 21'h100, 0, ST_OK, 16'h1234);
    run(OP_ID_ENTER, 21'h0, 0, ST_OK, 0);
    run(OP_READ, 21'h201, 0, ST_OK, dev_u.DEVC);
    run(OP_RESET, 21'h0, 0, ST_OK, 0);
    chk("suspended", 1, suspended);
    run(OP_RESUME, 21'h200, 0, ST_OK, 0);
    run(OP_RESUME, 21'h200, 0, ST_OK, 0);
    run(OP_POLL, 21'h200, 0, ST_OK, 16'h5678);
    run(OP_SUSPEND, 21'h200, 0, ST_OK, 0);
    chk("suspended", 0, suspended);
    endt("suspend");
    for (int k = 0; k < 4; k++)
      run(OP_BUF_LOAD, faddr_t'(21'h3000 + k), fdata_t'(16'h0a00 + k), ST_OK, 0);
    run(OP_BUF_PROG, 21'h3000, 16'h3, ST_OK, 0);
    run(OP_POLL, 21'h3003, 0, ST_OK, 16'h0a03);
    run(OP_READ, 21'h3001, 0, ST_OK, 16'h0a01);
    bad_cfm = 1;
    run(OP_BUF_LOAD, 21'h4000, 16'h0, ST_OK, 0);
    run(OP_BUF_PROG, 21'h4000, 16'h0, ST_OK, 0);
    run(OP_POLL, 21'h4000, 0, ST_ABORT, 0, 0);
    bad_cfm = 0;
    run(OP_ABORT_RST, 21'h0, 0, ST_OK, 0);
    run(OP_READ, 21'h4000, 0, ST_OK, 16'hffff);
    endt("buffer");
    report_and_stop();
  end
endmodule : nor_flash_command_sequencer_tb_top
`default_nettype wire
